// ==== config_write_protect.sv ====
// serial register slave with write protection of three settings registers
`timescale 1ns/1ps
`include "config_write_protect_params.svh"

// Behaviour
// RULE1: after reset the three settings registers are locked against writes.
// RULE2: the three unlock bits live in their own register at address 8.
// RULE3: bit 7 of the unlock register opens writes to feature settings.
// RULE4: bit 6 of the unlock register opens writes to charge settings.
// RULE5: bit 5 of the unlock register opens writes to discharge settings.
// RULE6: the master may clear each unlock bit, locking its register again.
// RULE7: the address steps after each data byte and wraps from 0x0a to 0.
// RULE8: a data byte is stored on the clock fall after its eighth bit.
// RULE9: the master never writes past address 0x0a into reserved space.
// RULE10: a locked write leaves the register as it was and is still acked.
module config_write_protect (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            sda_level,
	output logic            sda_oe,
	output logic [7:0]      discharge_cfg,
	output logic [7:0]      charge_cfg,
	output logic [7:0]      feature_cfg,
	output logic            feature_cfg_unlock,
	output logic            charge_cfg_unlock,
	output logic            discharge_cfg_unlock
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [3:0] next_ptr(input logic [3:0] a);
		if (a == `ADDR_LAST) begin
			return `ADDR_FIRST;
		end
		return a + 4'h1;
	endfunction : next_ptr

	function automatic logic [7:0] read_reg(
		input config_write_protect_pkg::regs_t m,
		input logic [3:0]                      a);
		if (a <= `ADDR_LAST) begin
			return m[a];
		end
		return 8'h00;
	endfunction : read_reg

	function automatic logic wr_allowed(
		input logic [3:0] a,
		input logic [7:0] en); // RULE2
		if (a == `ADDR_FEATURE) begin
			return en[`BIT_FEATURE_EN]; // RULE3
		end else if (a == `ADDR_CHARGE) begin
			return en[`BIT_CHARGE_EN]; // RULE4
		end else if (a == `ADDR_DISCHARGE) begin
			return en[`BIT_DISCHARGE_EN]; // RULE5
		end else if (a <= `ADDR_LAST) begin
			return 1'b1;
		end
		return 1'b0;
	endfunction : wr_allowed

	// ****************************************************************
	// state
	// ****************************************************************
	config_write_protect_pkg::state_t s_r;
	config_write_protect_pkg::state_t s_nxt;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_ev;
	logic       stop_ev;
	logic       wr_ev;
	logic       wr_ok;
	logic [7:0] rd_cur;
	logic [7:0] rd_next;

	assign scl_rise = s_r.scl_s2 & ~s_r.scl_s3;
	assign scl_fall = ~s_r.scl_s2 & s_r.scl_s3;
	assign start_ev = s_r.scl_s2 & s_r.scl_s3 & s_r.sda_s3 & ~s_r.sda_s2;
	assign stop_ev  = s_r.scl_s2 & s_r.scl_s3 & ~s_r.sda_s3 & s_r.sda_s2;
	assign wr_ev    = (s_r.ph == config_write_protect_pkg::ph_rx) & scl_fall
		& (s_r.bitcnt == `BITS_PER_BYTE)
		& (s_r.kind == config_write_protect_pkg::k_data);
	assign wr_ok    = wr_ev & wr_allowed(s_r.ptr, s_r.mem[`ADDR_UNLOCK]); // RULE10
	assign rd_cur   = read_reg(s_r.mem, s_r.ptr);
	assign rd_next  = read_reg(s_r.mem, next_ptr(s_r.ptr));

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.scl_s1 = scl;
		s_nxt.scl_s2 = s_r.scl_s1;
		s_nxt.scl_s3 = s_r.scl_s2;
		s_nxt.sda_s1 = sda;
		s_nxt.sda_s2 = s_r.sda_s1;
		s_nxt.sda_s3 = s_r.sda_s2;
		s_nxt.sda_level = 1'b0;
		case (s_r.ph)
			config_write_protect_pkg::ph_rx: begin
				if (scl_rise) begin
					s_nxt.shift  = {s_r.shift[6:0], s_r.sda_s2};
					s_nxt.bitcnt = s_r.bitcnt + 4'h1;
				end else if (scl_fall && s_r.bitcnt == `BITS_PER_BYTE) begin
					s_nxt.sda_oe = 1'b1;
					s_nxt.ph     = config_write_protect_pkg::ph_ack;
					case (s_r.kind)
						config_write_protect_pkg::k_slave: begin
							s_nxt.rw = s_r.shift[0];
							if (s_r.shift[7:1] != `SLAVE_ADDR) begin
								s_nxt.sda_oe = 1'b0;
								s_nxt.ph     = config_write_protect_pkg::ph_idle;
							end
						end
						config_write_protect_pkg::k_reg: begin
							s_nxt.ptr = s_r.shift[3:0];
						end
						default: begin
							if (wr_ok) begin // RULE6
								s_nxt.mem[s_r.ptr] = s_r.shift; // RULE8
							end
							s_nxt.ptr = next_ptr(s_r.ptr); // RULE7
						end
					endcase
				end
			end
			config_write_protect_pkg::ph_ack: begin
				if (scl_fall) begin
					s_nxt.sda_oe = 1'b0;
					s_nxt.bitcnt = 4'h0;
					if (s_r.kind == config_write_protect_pkg::k_slave
						&& s_r.rw) begin
						s_nxt.ph     = config_write_protect_pkg::ph_tx;
						s_nxt.shift  = rd_cur;
						s_nxt.sda_oe = ~rd_cur[7];
					end else begin
						s_nxt.ph = config_write_protect_pkg::ph_rx;
						if (s_r.kind == config_write_protect_pkg::k_slave) begin
							s_nxt.kind = config_write_protect_pkg::k_reg;
						end else begin
							s_nxt.kind = config_write_protect_pkg::k_data;
						end
					end
				end
			end
			config_write_protect_pkg::ph_tx: begin
				if (scl_fall) begin
					s_nxt.bitcnt = s_r.bitcnt + 4'h1;
					if (s_r.bitcnt == `LAST_TX_BIT) begin
						s_nxt.sda_oe = 1'b0;
						s_nxt.ph     = config_write_protect_pkg::ph_mack;
					end else begin
						s_nxt.shift  = {s_r.shift[6:0], 1'b0};
						s_nxt.sda_oe = ~s_r.shift[6];
					end
				end
			end
			config_write_protect_pkg::ph_mack: begin
				if (scl_rise) begin
					s_nxt.acked = ~s_r.sda_s2;
				end else if (scl_fall) begin
					if (s_r.acked) begin
						s_nxt.ptr    = next_ptr(s_r.ptr);
						s_nxt.shift  = rd_next;
						s_nxt.sda_oe = ~rd_next[7];
						s_nxt.bitcnt = 4'h0;
						s_nxt.ph     = config_write_protect_pkg::ph_tx;
					end else begin
						s_nxt.ph = config_write_protect_pkg::ph_idle;
					end
				end
			end
			default: begin
			end
		endcase
		if (start_ev) begin
			s_nxt.ph     = config_write_protect_pkg::ph_rx;
			s_nxt.kind   = config_write_protect_pkg::k_slave;
			s_nxt.bitcnt = 4'h0;
			s_nxt.sda_oe = 1'b0;
		end else if (stop_ev) begin
			s_nxt.ph     = config_write_protect_pkg::ph_idle;
			s_nxt.sda_oe = 1'b0;
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_r <= '0;
			s_r.scl_s1 <= 1'b1;
			s_r.scl_s2 <= 1'b1;
			s_r.scl_s3 <= 1'b1;
			s_r.sda_s1 <= 1'b1;
			s_r.sda_s2 <= 1'b1;
			s_r.sda_s3 <= 1'b1;
			s_r.mem[`ADDR_UNLOCK]    <= `UNLOCK_RESET; // RULE1
			s_r.mem[`ADDR_DISCHARGE] <= `CFG_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sda_level            = s_r.sda_level;
	assign sda_oe               = s_r.sda_oe;
	assign discharge_cfg        = s_r.mem[`ADDR_DISCHARGE];
	assign charge_cfg           = s_r.mem[`ADDR_CHARGE];
	assign feature_cfg          = s_r.mem[`ADDR_FEATURE];
	assign feature_cfg_unlock   = s_r.mem[`ADDR_UNLOCK][`BIT_FEATURE_EN];
	assign charge_cfg_unlock    = s_r.mem[`ADDR_UNLOCK][`BIT_CHARGE_EN];
	assign discharge_cfg_unlock = s_r.mem[`ADDR_UNLOCK][`BIT_DISCHARGE_EN];

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_locked_after_reset;
		!$past(nrst) |-> s_r.mem[`ADDR_UNLOCK] == 8'h00;
	endproperty
	a_locked_after_reset: assert property (p_locked_after_reset) // RULE1
		else $error("unlock register not cleared by reset");

	property p_unlock_own_reg;
		$changed(s_r.mem[`ADDR_UNLOCK])
			|-> $past(wr_ev && s_r.ptr == `ADDR_UNLOCK);
	endproperty
	a_unlock_own_reg: assert property (p_unlock_own_reg) // RULE2
		else $error("unlock bits changed without a write to address 8");

	property p_feature_gate;
		$changed(s_r.mem[`ADDR_FEATURE]) |-> $past(wr_ev
			&& s_r.ptr == `ADDR_FEATURE && feature_cfg_unlock);
	endproperty
	a_feature_gate: assert property (p_feature_gate) // RULE3
		else $error("feature settings changed while locked");

	property p_charge_gate;
		$changed(s_r.mem[`ADDR_CHARGE]) |-> $past(wr_ev
			&& s_r.ptr == `ADDR_CHARGE && charge_cfg_unlock);
	endproperty
	a_charge_gate: assert property (p_charge_gate) // RULE4
		else $error("charge settings changed while locked");

	property p_discharge_gate;
		$changed(s_r.mem[`ADDR_DISCHARGE]) |-> $past(wr_ev
			&& s_r.ptr == `ADDR_DISCHARGE && discharge_cfg_unlock);
	endproperty
	a_discharge_gate: assert property (p_discharge_gate) // RULE5
		else $error("discharge settings changed while locked");

	property p_unlock_clear;
		wr_ev && s_r.ptr == `ADDR_UNLOCK && s_r.shift == 8'h00
			|=> !feature_cfg_unlock && !charge_cfg_unlock
			&& !discharge_cfg_unlock ##1 !feature_cfg_unlock;
	endproperty
	a_unlock_clear: assert property (p_unlock_clear) // RULE6
		else $error("clearing unlock bits did not relock");

	property p_addr_step;
		wr_ev |=> s_r.ptr == ($past(s_r.ptr) == `ADDR_LAST
			? `ADDR_FIRST : $past(s_r.ptr) + 4'h1);
	endproperty
	a_addr_step: assert property (p_addr_step) // RULE7
		else $error("address did not step or wrap after data byte");

	property p_commit;
		wr_ok |=> sda_oe && read_reg(s_r.mem, $past(s_r.ptr))
			== $past(s_r.shift);
	endproperty
	a_commit: assert property (p_commit) // RULE8
		else $error("data byte not stored on the fall after bit 8");

	property p_locked_write;
		wr_ev && !wr_ok |=> $stable(s_r.mem) && sda_oe;
	endproperty
	a_locked_write: assert property (p_locked_write) // RULE10
		else $error("locked write altered a register or was not acked");

	c_unlocked_write: cover property (wr_ok && s_r.ptr == `ADDR_FEATURE);
	c_locked_write: cover property (wr_ev && !wr_ok);
	c_wrap: cover property (s_r.ph == config_write_protect_pkg::ph_mack
		&& scl_fall && s_r.acked && s_r.ptr == `ADDR_LAST);
	c_read: cover property (s_r.ph == config_write_protect_pkg::ph_mack
		&& scl_fall && s_r.acked);

endmodule : config_write_protect

// ==== config_write_protect_params.svh ====
// offsets, field positions, reset values and counts of the protection gate
`ifndef CONFIG_WRITE_PROTECT_PARAMS_SVH
`define CONFIG_WRITE_PROTECT_PARAMS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define ADDR_DISCHARGE   4'h5
`define ADDR_CHARGE      4'h6
`define ADDR_FEATURE     4'h7
`define ADDR_UNLOCK      4'h8
`define ADDR_LAST        4'ha
`define ADDR_FIRST       4'h0
`define REG_COUNT        11

// ****************************************************************
// unlock register fields and reset values
// ****************************************************************
`define BIT_FEATURE_EN   7
`define BIT_CHARGE_EN    6
`define BIT_DISCHARGE_EN 5
`define UNLOCK_RESET     8'h00
`define CFG_RESET        8'h00

// ****************************************************************
// serial framing
// ****************************************************************
`define BITS_PER_BYTE    4'h8
`define LAST_TX_BIT      4'h7
// bus address of this slave, value arbitrary
`define SLAVE_ADDR       7'h2c

`endif

// ==== config_write_protect_pkg.sv ====
// types of the configuration write-protection gate
`include "config_write_protect_params.svh"
package config_write_protect_pkg;

	typedef enum logic [2:0] {ph_idle, ph_rx, ph_ack, ph_tx, ph_mack} phase_t;
	typedef enum logic [1:0] {k_slave, k_reg, k_data} kind_t;
	typedef logic [`REG_COUNT-1:0][7:0] regs_t;

	typedef struct packed {
		logic       scl_s1;
		logic       scl_s2;
		logic       scl_s3;
		logic       sda_s1;
		logic       sda_s2;
		logic       sda_s3;
		phase_t     ph;
		kind_t      kind;
		logic [3:0] bitcnt;
		logic [7:0] shift;
		logic [3:0] ptr;
		logic       rw;
		logic       acked;
		logic       sda_oe;
		logic       sda_level;
		regs_t      mem;
	} state_t;

endpackage : config_write_protect_pkg

// ==== i2c_master_model.sv ====
// bus master model driving the serial pins of the protection gate
`timescale 1ns/1ps
module i2c_master_model (
	input  wire logic clk,
	input  wire logic sda_oe,
	output logic      scl,
	output wire logic sda
);
	logic drv;

	// open drain wire with pull-up
	assign sda = drv & ~sda_oe;

	initial begin
		scl = 1'b1;
		drv = 1'b1;
	end

	task automatic half;
		repeat (10) @(posedge clk);
	endtask : half

	task automatic start;
		@(posedge clk);
		drv <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		drv <= 1'b0;
		half();
		scl <= 1'b0;
	endtask : start

	task automatic stop;
		@(posedge clk);
		drv <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		drv <= 1'b1;
		half();
	endtask : stop

	task automatic bit_io(input logic b, output logic r);
		@(posedge clk);
		drv <= b;
		half();
		scl <= 1'b1;
		half();
		r = sda;
		scl <= 1'b0;
	endtask : bit_io

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask : wbyte

	task automatic rbyte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(~mack, r);
	endtask : rbyte
endmodule : i2c_master_model

// ==== config_write_protect_tb_top.sv ====
// self-checking bench of the configuration write-protection gate
`timescale 1ns/1ps
`include "config_write_protect_params.svh"
module config_write_protect_tb_top;
	logic       clk;
	logic       nrst;
	logic       scl;
	logic       sda;
	logic       sda_level;
	logic       sda_oe;
	logic [7:0] dis;
	logic [7:0] chg;
	logic [7:0] fea;
	logic       fu;
	logic       cu;
	logic       du;
	logic [7:0] exp_m [0:10];
	logic [7:0] tbl [0:5];
	logic       ack;
	int         errors;
	int         n_checks;

	config_write_protect dut (.clk(clk), .nrst(nrst), .scl(scl), .sda(sda),
		.sda_level(sda_level), .sda_oe(sda_oe), .discharge_cfg(dis),
		.charge_cfg(chg), .feature_cfg(fea), .feature_cfg_unlock(fu),
		.charge_cfg_unlock(cu), .discharge_cfg_unlock(du));
	i2c_master_model m (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_checks++;
		if (seen !== want) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask : check

	task automatic tally_and_finish;
		if (errors == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	function automatic logic [7:0] r8;
		return 8'($urandom);
	endfunction : r8

	function automatic logic allowed(input logic [3:0] a);
		case (a)
			`ADDR_FEATURE:   return exp_m[8][`BIT_FEATURE_EN];
			`ADDR_CHARGE:    return exp_m[8][`BIT_CHARGE_EN];
			`ADDR_DISCHARGE: return exp_m[8][`BIT_DISCHARGE_EN];
			default:         return 1'b1;
		endcase
	endfunction : allowed

	function automatic logic [3:0] nxt(input logic [3:0] a);
		return (a == `ADDR_LAST) ? `ADDR_FIRST : a + 4'h1;
	endfunction : nxt

	task automatic check_outs;
		check(dis, exp_m[5]);
		check(chg, exp_m[6]);
		check(fea, exp_m[7]);
		check({fu, cu, du, 5'h00}, exp_m[8] & 8'he0);
	endtask : check_outs

	// bursts step the address after each byte and wrap from 0x0a to 0
	task automatic wr(input logic [3:0] a, input logic [7:0] q[$]);
		m.start();
		m.wbyte({`SLAVE_ADDR, 1'b0}, ack);
		m.wbyte({4'h0, a}, ack);
		foreach (q[i]) begin
			m.wbyte(q[i], ack);
			check({7'h00, ack}, 8'h01);
			check({7'h00, sda_level}, 8'h00);
			if (allowed(a)) exp_m[a] = q[i];
			a = nxt(a);
			check_outs();
		end
		m.stop();
	endtask : wr

	task automatic rd(input logic [3:0] a, input int n);
		logic [7:0] d;
		m.start();
		m.wbyte({`SLAVE_ADDR, 1'b0}, ack);
		m.wbyte({4'h0, a}, ack);
		m.start();
		m.wbyte({`SLAVE_ADDR, 1'b1}, ack);
		for (int i = 0; i < n; i++) begin
			m.rbyte(i < n - 1, d);
			check(d, (a <= `ADDR_LAST) ? exp_m[a] : 8'h00);
			a = nxt(a);
		end
		m.stop();
	endtask : rd

	// ****************************************************************
	// clock, watchdog, main sequence
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#1_000_000;
		errors++;
		tally_and_finish();
	end

	initial begin
		nrst = 1'b0;
		errors = 0;
		n_checks = 0;
		void'($urandom(32'h0f7edd01));
		foreach (exp_m[i]) exp_m[i] = `CFG_RESET;
		exp_m[8] = `UNLOCK_RESET;
		tbl = '{8'he0, 8'h80, 8'h40, 8'h20, 8'h00, r8()};
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (5) @(posedge clk);
		check_outs();
		wr(`ADDR_DISCHARGE, '{r8(), r8(), r8()});
		foreach (tbl[k]) begin
			wr(`ADDR_UNLOCK, '{tbl[k]});
			wr(`ADDR_DISCHARGE, '{r8(), r8(), r8()});
		end
		wr(`ADDR_UNLOCK, '{8'he0});
		wr(`ADDR_DISCHARGE, '{r8(), r8(), r8(), 8'h00});
		wr(`ADDR_FIRST, '{r8(), r8()});
		rd(4'h4, 5);
		rd(4'h9, 4);
		rd(4'hf, 2);
		wr(`ADDR_UNLOCK, '{8'he0});
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		foreach (exp_m[i]) exp_m[i] = `CFG_RESET;
		exp_m[8] = `UNLOCK_RESET;
		repeat (5) @(posedge clk);
		check_outs();
		wr(`ADDR_FEATURE, '{r8()});
		m.start();
		m.wbyte({`SLAVE_ADDR ^ 7'h01, 1'b0}, ack);
		check({7'h00, ack}, 8'h00);
		m.stop();
		tally_and_finish();
	end
endmodule : config_write_protect_tb_top
